// ---- design/sbr_char_buf.sv ----
// Transmit and receive holding buffers with their status flags.
// Assumes frame logic on the bus clock; strobes are one-cycle pulses.
`timescale 1ns/100ps
`include "sbr_consts.svh"
module sbr_char_buf import sbr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic data_wr,
	input wire logic [7:0] wr_data,
	input wire logic data_rd,
	input wire logic status_rd,
	input wire logic tx_load_ready,
	output logic tx_load_valid,
	output logic [7:0] tx_load_data,
	input wire logic tx_done,
	input wire logic rx_idle,
	input wire logic rx_char_valid,
	input wire sbr_rx_char_s rx_char,
	output logic [7:0] rx_holding_buffer,
	output logic rx_bit8,
	output logic [7:0] status
);
	logic tx_full_reg;
	logic tc_reg;
	logic arm_reg;
	logic rx_full_flag;
	logic idle_reg;
	logic ovr_reg;
	logic nf_reg;
	logic fe_reg;
	logic pe_reg;
	logic tx_fire;
	logic clr_rx;
	logic rx_room;
	logic rx_accept;
	logic rx_overrun;

	assign tx_load_valid = tx_full_reg;
	assign tx_fire = tx_full_reg && tx_load_ready;
	assign clr_rx = arm_reg && data_rd;
	assign rx_room = !rx_full_flag || clr_rx;
	assign rx_accept = rx_char_valid && rx_room;
	assign rx_overrun = rx_char_valid && !rx_room;

	// A write in the load cycle keeps the buffer full
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_full_reg <= 1'b0;
			tx_load_data <= `SBR_BYTE_ZERO;
		end else begin
			if (data_wr) begin // RULE_01
				tx_full_reg <= 1'b1;
				tx_load_data <= wr_data;
			end else if (tx_fire) begin // RULE_02
				tx_full_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_reg <= 1'b0;
		end else if (status_rd) begin
			arm_reg <= 1'b1;
		end else if (data_rd || data_wr) begin
			arm_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tc_reg <= 1'b1;
		end else if (tx_done) begin
			tc_reg <= 1'b1;
		end else if (arm_reg && data_wr) begin
			tc_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_holding_buffer <= `SBR_BYTE_ZERO;
			rx_bit8 <= 1'b0;
		end else if (rx_accept) begin // RULE_03
			rx_holding_buffer <= rx_char.data;
			rx_bit8 <= rx_char.bit8;
		end
	end

	// Hardware set wins over the software clear sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_flag <= 1'b0;
			idle_reg <= 1'b0;
			ovr_reg <= 1'b0;
			nf_reg <= 1'b0;
			fe_reg <= 1'b0;
			pe_reg <= 1'b0;
		end else begin
			rx_full_flag <= rx_accept || (rx_full_flag && !clr_rx); // RULE_13
			idle_reg <= rx_idle || (idle_reg && !clr_rx);
			ovr_reg <= rx_overrun || (ovr_reg && !clr_rx);
			nf_reg <= (rx_accept && rx_char.noise) || (nf_reg && !clr_rx);
			fe_reg <= (rx_accept && rx_char.framing) || (fe_reg && !clr_rx);
			pe_reg <= (rx_accept && rx_char.parity) || (pe_reg && !clr_rx);
		end
	end

	always_comb begin
		status = `SBR_BYTE_ZERO;
		status[`SBR_ST_TDRE] = !tx_full_reg;
		status[`SBR_ST_TC] = tc_reg;
		status[`SBR_ST_RX_FULL_FLAG] = rx_full_flag;
		status[`SBR_ST_IDLE] = idle_reg;
		status[`SBR_ST_OR] = ovr_reg;
		status[`SBR_ST_NF] = nf_reg;
		status[`SBR_ST_FE] = fe_reg;
		status[`SBR_ST_PE] = pe_reg;
	end
endmodule

// ---- design/sbr_rate_gen.sv ----
// One rate divider chain: first stage, power-of-two stage, fixed 16, extended.
// Assumes restart is a one-cycle pulse from register writes.
`timescale 1ns/100ps
`include "sbr_consts.svh"
module sbr_rate_gen import sbr_pkg::*; #(
	parameter int STAGE_W = 8,
	parameter int EXT_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] first_stage_select,
	input wire logic [2:0] stage_select,
	input wire logic [EXT_W-1:0] ext_divisor,
	input wire logic restart,
	input wire logic run,
	output logic bit_tick
);
	logic [3:0] first_stage_factor;
	logic [STAGE_W-1:0] stage_factor;
	logic [3:0] pre_cnt_reg;
	logic [STAGE_W-1:0] stage_cnt_reg;
	logic [3:0] fix_cnt_reg;
	logic [EXT_W-1:0] ext_cnt_reg;
	logic pre_hit;
	logic stage_hit;
	logic fix_hit;
	logic ext_hit;
	logic ext_on;

	always_comb begin
		case (first_stage_select) // RULE_04
			`SBR_FIRST_SEL_00: first_stage_factor = `SBR_FIRST_FACT_00;
			`SBR_FIRST_SEL_01: first_stage_factor = `SBR_FIRST_FACT_01;
			`SBR_FIRST_SEL_10: first_stage_factor = `SBR_FIRST_FACT_10;
			default: first_stage_factor = `SBR_FIRST_FACT_11;
		endcase
	end

	assign stage_factor = STAGE_W'(1) << stage_select; // RULE_05 RULE_06
	assign ext_on = (ext_divisor != '0);
	assign pre_hit = run && (pre_cnt_reg == first_stage_factor - 4'h1);
	assign stage_hit = pre_hit && (stage_cnt_reg == stage_factor - STAGE_W'(1));
	assign fix_hit = stage_hit && (fix_cnt_reg == `SBR_FIXED_LAST); // RULE_07 RULE_08
	assign ext_hit = fix_hit && (!ext_on || ext_cnt_reg == ext_divisor - EXT_W'(1)); // RULE_09 RULE_10

	// Restart drops partial counts so no short bit follows a rate change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_reg <= '0;
			stage_cnt_reg <= '0;
			fix_cnt_reg <= '0;
			ext_cnt_reg <= '0;
		end else if (restart) begin // RULE_15
			pre_cnt_reg <= '0;
			stage_cnt_reg <= '0;
			fix_cnt_reg <= '0;
			ext_cnt_reg <= '0;
		end else if (run) begin // RULE_14
			pre_cnt_reg <= pre_hit ? 4'h0 : pre_cnt_reg + 4'h1;
			if (pre_hit) begin
				stage_cnt_reg <= stage_hit ? '0 : stage_cnt_reg + STAGE_W'(1);
			end
			if (stage_hit) begin
				fix_cnt_reg <= fix_cnt_reg + 4'h1;
			end
			if (fix_hit) begin
				ext_cnt_reg <= (ext_hit || !ext_on) ? '0 : ext_cnt_reg + EXT_W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_tick <= 1'b0;
		end else begin
			bit_tick <= ext_hit && !restart;
		end
	end
endmodule

// ---- design/sbr_top.sv ----
// Serial rate and data registers: APB slave, holding buffers, rate chains.
// Assumes frame shifting logic on pclk drives the load, receive and busy strobes.
//
// Behaviour
// [RULE_01] The data port is one address: writes go to the transmit buffer, reads return receive.
// [RULE_02] The transmit buffer hands its character to the output shift register.
// [RULE_03] An assembled received character loads the receive buffer for the bus to read.
// [RULE_04] First-stage select 00, 01, 10, 11 divides by 1, 3, 4 and 13.
// [RULE_05] Transmit rate field bits 5 to 3 divides by two to the power of its value.
// [RULE_06] Receive rate field bits 2 to 0 divides by two to the power of its value.
// [RULE_07] Transmit bit rate is bus clock over first stage, transmit stage and 16.
// [RULE_08] Receive bit rate is bus clock over first stage, receive stage and 16, on its own.
// [RULE_09] A nonzero receive extended divisor further divides the receive clock after the 16.
// [RULE_10] A nonzero transmit extended divisor further divides the transmit clock after the 16.
// [RULE_11] Both extended divisors reset to zero, so extended division starts bypassed.
// [RULE_12] Registers sit at indexes 50h to 55h and 57h.
// [RULE_13] Status access followed by a data read clears receive full and error flags.
// [RULE_14] Power-down stops the prescalers and outputs at the end of the current byte.
// [RULE_15] Rewriting a rate field restarts both divider chains from zero.
`timescale 1ns/100ps
`include "sbr_consts.svh"
module sbr_top import sbr_pkg::*; #(
	parameter int ADDR_W = 12,
	parameter int EXT_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic tx_load_valid,
	input wire logic tx_load_ready,
	output logic [7:0] tx_load_data,
	input wire logic tx_done,
	input wire logic rx_char_valid,
	input wire sbr_rx_char_s rx_char,
	input wire logic rx_idle,
	input wire logic xfer_busy,
	output sbr_ctrl_s ctrl,
	output logic tx_bit_tick,
	output logic rx_bit_tick,
	output logic serial_outputs_off
);
	logic [7:0] rate_reg;
	logic [6:0] ctrl1_reg;
	logic [7:0] ctrl2_reg;
	logic [EXT_W-1:0] rx_ext_reg;
	logic [EXT_W-1:0] tx_ext_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic setup;
	logic access;
	logic wr_en;
	logic rd_en;
	logic [9:0] idx;
	logic mapped;
	logic [7:0] rd_byte;
	logic data_wr;
	logic data_rd;
	logic status_rd;
	logic [7:0] status;
	logic [7:0] rx_holding_buffer;
	logic rx_bit8;
	logic serial_power_down;
	logic rate_run;
	logic tx_restart;
	logic rx_restart;
	logic [7:0] ctrl_one_full;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr_en = access && pwrite;
	assign rd_en = access && !pwrite;
	assign idx = paddr[`SBR_IDX_HI:`SBR_IDX_LO];
	assign pready = access;
	assign pslverr = access && pslverr_reg;
	assign prdata = prdata_reg;

	assign data_wr = wr_en && (idx == `SBR_IDX_DATA);
	assign data_rd = rd_en && (idx == `SBR_IDX_DATA);
	assign status_rd = rd_en && (idx == `SBR_IDX_STATUS);

	always_comb begin
		ctrl_one_full = {1'b0, ctrl1_reg};
		ctrl_one_full[`SBR_C1_R8] = rx_bit8;
	end

	always_comb begin
		mapped = 1'b1;
		case (idx) // RULE_12
			`SBR_IDX_STATUS: rd_byte = status;
			`SBR_IDX_DATA: rd_byte = rx_holding_buffer; // RULE_01
			`SBR_IDX_RATE: rd_byte = rate_reg;
			`SBR_IDX_CTRL1: rd_byte = ctrl_one_full;
			`SBR_IDX_CTRL2: rd_byte = ctrl2_reg;
			`SBR_IDX_RXEXT: rd_byte = rx_ext_reg;
			`SBR_IDX_TXEXT: rd_byte = tx_ext_reg;
			default: begin
				rd_byte = `SBR_BYTE_ZERO;
				mapped = 1'b0;
			end
		endcase
	end

	// Read data is captured in the setup cycle so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= `SBR_WORD_ZERO;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg <= pwrite ? `SBR_WORD_ZERO : {24'h000000, rd_byte};
			pslverr_reg <= !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_reg <= `SBR_RATE_RST;
			ctrl1_reg <= `SBR_CTRL1_RST;
			ctrl2_reg <= `SBR_CTRL2_RST;
			rx_ext_reg <= `SBR_EXT_RST; // RULE_11
			tx_ext_reg <= `SBR_EXT_RST; // RULE_11
		end else if (wr_en) begin
			case (idx)
				`SBR_IDX_RATE: rate_reg <= pwdata[7:0];
				`SBR_IDX_CTRL1: ctrl1_reg <= pwdata[6:0];
				`SBR_IDX_CTRL2: ctrl2_reg <= pwdata[7:0];
				`SBR_IDX_RXEXT: rx_ext_reg <= pwdata[EXT_W-1:0];
				`SBR_IDX_TXEXT: tx_ext_reg <= pwdata[EXT_W-1:0];
				default: ;
			endcase
		end
	end

	assign ctrl.ctrl_one = ctrl_one_full;
	assign ctrl.ctrl_two = ctrl2_reg;

	// Busy holds the chains running until the byte in flight is done
	assign serial_power_down = ctrl1_reg[`SBR_C1_PD];
	assign rate_run = !serial_power_down || xfer_busy; // RULE_14
	assign serial_outputs_off = serial_power_down && !xfer_busy; // RULE_14
	assign tx_restart = wr_en && (idx == `SBR_IDX_RATE || idx == `SBR_IDX_TXEXT); // RULE_15
	assign rx_restart = wr_en && (idx == `SBR_IDX_RATE || idx == `SBR_IDX_RXEXT); // RULE_15

	sbr_char_buf u_buf (
		.pclk(pclk),
		.presetn(presetn),
		.data_wr(data_wr),
		.wr_data(pwdata[7:0]),
		.data_rd(data_rd),
		.status_rd(status_rd),
		.tx_load_ready(tx_load_ready),
		.tx_load_valid(tx_load_valid),
		.tx_load_data(tx_load_data),
		.tx_done(tx_done),
		.rx_idle(rx_idle),
		.rx_char_valid(rx_char_valid),
		.rx_char(rx_char),
		.rx_holding_buffer(rx_holding_buffer),
		.rx_bit8(rx_bit8),
		.status(status)
	);

	sbr_rate_gen #(.STAGE_W(8), .EXT_W(EXT_W)) u_tx_rate (
		.pclk(pclk),
		.presetn(presetn),
		.first_stage_select(rate_reg[`SBR_FIRST_HI:`SBR_FIRST_LO]),
		.stage_select(rate_reg[`SBR_TXR_HI:`SBR_TXR_LO]),
		.ext_divisor(tx_ext_reg),
		.restart(tx_restart),
		.run(rate_run),
		.bit_tick(tx_bit_tick)
	);

	sbr_rate_gen #(.STAGE_W(8), .EXT_W(EXT_W)) u_rx_rate (
		.pclk(pclk),
		.presetn(presetn),
		.first_stage_select(rate_reg[`SBR_FIRST_HI:`SBR_FIRST_LO]),
		.stage_select(rate_reg[`SBR_RXR_HI:`SBR_RXR_LO]),
		.ext_divisor(rx_ext_reg),
		.restart(rx_restart),
		.run(rate_run),
		.bit_tick(rx_bit_tick)
	);

	// Checking helpers: expected tick spacing and cycles since the last tick
	function automatic logic [23:0] exp_period(input logic [1:0] fs, input logic [2:0] ss,
		input logic [7:0] ext);
		logic [23:0] f;
		logic [23:0] e;
		case (fs)
			`SBR_FIRST_SEL_00: f = 24'(`SBR_FIRST_FACT_00);
			`SBR_FIRST_SEL_01: f = 24'(`SBR_FIRST_FACT_01);
			`SBR_FIRST_SEL_10: f = 24'(`SBR_FIRST_FACT_10);
			default: f = 24'(`SBR_FIRST_FACT_11);
		endcase
		e = (ext == 8'h00) ? 24'h000001 : 24'(ext);
		return 24'(f * (24'h000001 << ss) * `SBR_FIXED_DIV * e);
	endfunction

	logic [23:0] tx_gap_reg;
	logic [23:0] rx_gap_reg;
	logic tx_clean_reg;
	logic rx_clean_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_gap_reg <= 24'h000000;
			tx_clean_reg <= 1'b0;
		end else begin
			tx_gap_reg <= tx_bit_tick ? 24'h000001 : tx_gap_reg + 24'h000001;
			if (tx_restart || !rate_run) begin
				tx_clean_reg <= 1'b0;
			end else if (tx_bit_tick) begin
				tx_clean_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_gap_reg <= 24'h000000;
			rx_clean_reg <= 1'b0;
		end else begin
			rx_gap_reg <= rx_bit_tick ? 24'h000001 : rx_gap_reg + 24'h000001;
			if (rx_restart || !rate_run) begin
				rx_clean_reg <= 1'b0;
			end else if (rx_bit_tick) begin
				rx_clean_reg <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_tx_period;
		tx_bit_tick && tx_clean_reg |-> tx_gap_reg == exp_period(
			rate_reg[`SBR_FIRST_HI:`SBR_FIRST_LO], rate_reg[`SBR_TXR_HI:`SBR_TXR_LO], tx_ext_reg);
	endproperty
	a_tx_period: assert property (p_tx_period) else $error("tx tick spacing wrong"); // RULE_07

	property p_rx_period;
		rx_bit_tick && rx_clean_reg |-> rx_gap_reg == exp_period(
			rate_reg[`SBR_FIRST_HI:`SBR_FIRST_LO], rate_reg[`SBR_RXR_HI:`SBR_RXR_LO], rx_ext_reg);
	endproperty
	a_rx_period: assert property (p_rx_period) else $error("rx tick spacing wrong"); // RULE_08

	property p_unmapped_err;
		access && !(idx inside {`SBR_IDX_STATUS, `SBR_IDX_DATA, `SBR_IDX_RATE, `SBR_IDX_CTRL1,
			`SBR_IDX_CTRL2, `SBR_IDX_RXEXT, `SBR_IDX_TXEXT}) |-> pslverr && pready;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped not flagged"); // RULE_12

	property p_tx_write;
		data_wr |=> tx_load_valid && tx_load_data == $past(pwdata[7:0]) && !status[`SBR_ST_TDRE];
	endproperty
	a_tx_write: assert property (p_tx_write) else $error("data write lost"); // RULE_01

	property p_tx_handoff;
		tx_load_valid && tx_load_ready && !data_wr |=> status[`SBR_ST_TDRE] && !tx_load_valid;
	endproperty
	a_tx_handoff: assert property (p_tx_handoff) else $error("tx buffer not emptied"); // RULE_02

	property p_rx_load;
		rx_char_valid && !status[`SBR_ST_RX_FULL_FLAG] |=> status[`SBR_ST_RX_FULL_FLAG] &&
			rx_holding_buffer == $past(rx_char.data);
	endproperty
	a_rx_load: assert property (p_rx_load) else $error("rx char not loaded"); // RULE_03

	// Fixed gap of one idle and one setup cycle between the two accesses
	sequence s_clear_seq;
		status_rd ##1 (!data_rd && !data_wr) [*2] ##1 data_rd;
	endsequence
	property p_rx_clear;
		s_clear_seq ##0 !rx_char_valid && !rx_idle |=> !status[`SBR_ST_RX_FULL_FLAG] &&
			status[4:0] == 5'h00;
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("clear sequence failed"); // RULE_13

	property p_power_down;
		!rate_run |=> !tx_bit_tick && !rx_bit_tick;
	endproperty
	a_power_down: assert property (p_power_down) else $error("ticks while stopped"); // RULE_14

	property p_restart;
		tx_restart ##1 rate_run [*3] |-> !tx_bit_tick [*3];
	endproperty
	a_restart: assert property (p_restart) else $error("tick soon after restart"); // RULE_15

	property p_ext_reset;
		$rose(presetn) |-> rx_ext_reg == `SBR_EXT_RST && tx_ext_reg == `SBR_EXT_RST;
	endproperty
	a_ext_reset: assert property (p_ext_reset) else $error("ext divisor not cleared"); // RULE_11

	property p_overrun;
		rx_char_valid && status[`SBR_ST_RX_FULL_FLAG] && !data_rd |=> status[`SBR_ST_OR] &&
			$stable(rx_holding_buffer);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun mishandled"); // RULE_03

	c_tx_handoff: cover property (tx_load_valid && tx_load_ready);
	c_overrun: cover property (rx_char_valid && status[`SBR_ST_RX_FULL_FLAG]);
	c_ext_tick: cover property (tx_bit_tick && tx_ext_reg != `SBR_EXT_RST);
	c_power_down: cover property (serial_power_down && xfer_busy ##1 !xfer_busy);
endmodule

// ---- include/sbr_consts.svh ----
// Constants for the serial rate and data register block.
// Assumes inclusion by bare name from design files.
`ifndef SBR_CONSTS_SVH
`define SBR_CONSTS_SVH

// Register indexes; byte address is four times the index
`define SBR_IDX_STATUS 10'h050
`define SBR_IDX_DATA 10'h051
`define SBR_IDX_RATE 10'h052
`define SBR_IDX_CTRL1 10'h053
`define SBR_IDX_CTRL2 10'h054
`define SBR_IDX_RXEXT 10'h055
`define SBR_IDX_TXEXT 10'h057
`define SBR_IDX_HI 11
`define SBR_IDX_LO 2

// Rate select fields
`define SBR_FIRST_HI 7
`define SBR_FIRST_LO 6
`define SBR_TXR_HI 5
`define SBR_TXR_LO 3
`define SBR_RXR_HI 2
`define SBR_RXR_LO 0

// First-stage factors
`define SBR_FIRST_SEL_00 2'h0
`define SBR_FIRST_SEL_01 2'h1
`define SBR_FIRST_SEL_10 2'h2
`define SBR_FIRST_FACT_00 4'h1
`define SBR_FIRST_FACT_01 4'h3
`define SBR_FIRST_FACT_10 4'h4
`define SBR_FIRST_FACT_11 4'hD
`define SBR_FIXED_DIV 24'h000010
`define SBR_FIXED_LAST 4'hF

// Status bit positions
`define SBR_ST_TDRE 7
`define SBR_ST_TC 6
`define SBR_ST_RX_FULL_FLAG 5
`define SBR_ST_IDLE 4
`define SBR_ST_OR 3
`define SBR_ST_NF 2
`define SBR_ST_FE 1
`define SBR_ST_PE 0

// Control one bit positions
`define SBR_C1_R8 7
`define SBR_C1_PD 5

// Reset values
`define SBR_RATE_RST 8'h00
`define SBR_CTRL1_RST 7'h00
`define SBR_CTRL2_RST 8'h00
`define SBR_EXT_RST 8'h00
`define SBR_BYTE_ZERO 8'h00
`define SBR_WORD_ZERO 32'h00000000

`endif

// ---- include/sbr_pkg.sv ----
// Types shared by the serial rate and data register block.
// Assumes the frame logic outside shares the bus clock.
package sbr_pkg;

	typedef struct packed {
		logic [7:0] data;
		logic bit8;
		logic noise;
		logic framing;
		logic parity;
	} sbr_rx_char_s;

	typedef struct packed {
		logic [7:0] ctrl_one;
		logic [7:0] ctrl_two;
	} sbr_ctrl_s;

endpackage

// ---- testbench/sbr_far_model.sv ----
// Far side stand-in: frame shift logic taking characters and delivering received ones.
// Assumes the bench requests received characters with one-cycle send pulses on pclk.
`timescale 1ns/100ps
module sbr_far_model import sbr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tx_load_valid,
	input wire logic [7:0] tx_load_data,
	output logic tx_load_ready,
	output logic tx_done,
	output logic xfer_busy,
	output logic rx_char_valid,
	output sbr_rx_char_s rx_char,
	output logic rx_idle,
	input wire logic send_req,
	input wire logic [7:0] send_data,
	input wire logic send_bit8,
	output logic [7:0] got_data,
	output logic [7:0] got_count
);
	logic [4:0] stall_reg;

	// Busy for a frame after each take, so a back-to-back character waits in the transmit buffer
	assign tx_load_ready = (stall_reg == 5'h00);
	assign xfer_busy = (stall_reg != 5'h00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_reg <= 5'h00;
			got_data <= 8'h00;
			got_count <= 8'h00;
		end else if (tx_load_valid && tx_load_ready) begin
			stall_reg <= 5'h14;
			got_data <= tx_load_data;
			got_count <= got_count + 8'h01;
		end else if (stall_reg != 5'h00) begin
			stall_reg <= stall_reg - 5'h01;
		end
	end

	// Outside a delivery the character lines invert every cycle, so they never hold steady
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_done <= 1'h0;
			rx_char_valid <= 1'h0;
			rx_char <= '0;
			rx_idle <= 1'h0;
		end else begin
			tx_done <= (stall_reg == 5'h01);
			rx_char_valid <= send_req;
			rx_char <= send_req ? {send_data, send_bit8, 3'h0} : ~rx_char;
			rx_idle <= 1'h0;
		end
	end
endmodule

// ---- testbench/tb_sbr_top.sv ----
// Self-checking bench for the serial rate and data register block.
// Assumes the far side model and the design's package and constants header.
`timescale 1ns/100ps
`include "sbr_consts.svh"
module tb_sbr_top import sbr_pkg::*;;
	typedef struct packed {logic wr; logic [9:0] idx; logic [7:0] d; logic [7:0] exp; logic err;} sbr_tb_reg_s;
	typedef struct packed {logic [7:0] rate; logic [7:0] txe; logic [7:0] rxe; logic [31:0] txp; logic [31:0] rxp;} sbr_tb_rate_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, n;
	logic tx_load_valid, tx_load_ready, tx_done, rx_char_valid, rx_idle, xfer_busy;
	logic tx_bit_tick, rx_bit_tick, serial_outputs_off, send_req, send_bit8;
	logic [7:0] tx_load_data, send_data, got_data, got_count;
	sbr_rx_char_s rx_char;
	sbr_ctrl_s ctrl;
	int mismatches, checks;
	sbr_tb_reg_s reg_rows [17] = '{
		'{1'h0, `SBR_IDX_STATUS, 8'h00, 8'hC0, 1'h0}, '{1'h0, `SBR_IDX_RATE, 8'h00, 8'h00, 1'h0},
		'{1'h0, `SBR_IDX_RXEXT, 8'h00, 8'h00, 1'h0}, '{1'h0, `SBR_IDX_TXEXT, 8'h00, 8'h00, 1'h0},
		'{1'h0, `SBR_IDX_CTRL2, 8'h00, 8'h00, 1'h0}, '{1'h1, `SBR_IDX_RATE, 8'h5A, 8'h00, 1'h0},
		'{1'h0, `SBR_IDX_RATE, 8'h00, 8'h5A, 1'h0}, '{1'h1, `SBR_IDX_RXEXT, 8'h81, 8'h00, 1'h0},
		'{1'h0, `SBR_IDX_RXEXT, 8'h00, 8'h81, 1'h0}, '{1'h1, `SBR_IDX_TXEXT, 8'h7E, 8'h00, 1'h0},
		'{1'h0, `SBR_IDX_TXEXT, 8'h00, 8'h7E, 1'h0}, '{1'h1, `SBR_IDX_CTRL2, 8'h3C, 8'h00, 1'h0},
		'{1'h0, `SBR_IDX_CTRL2, 8'h00, 8'h3C, 1'h0}, '{1'h1, `SBR_IDX_STATUS, 8'h00, 8'h00, 1'h0},
		'{1'h0, `SBR_IDX_STATUS, 8'h00, 8'hC0, 1'h0}, '{1'h0, 10'h056, 8'h00, 8'h00, 1'h1},
		'{1'h1, 10'h056, 8'hFF, 8'h00, 1'h1}};
	sbr_tb_rate_s rate_rows [5] = '{
		'{8'h00, 8'h00, 8'h00, 32'h10, 32'h10}, '{8'h4A, 8'h00, 8'h00, 32'h60, 32'hC0},
		'{8'h9F, 8'h00, 8'h00, 32'h200, 32'h2000}, '{8'hE0, 8'h00, 8'h00, 32'hD00, 32'hD0},
		'{8'h00, 8'h03, 8'hFF, 32'h30, 32'hFF0}};

	sbr_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_load_valid(tx_load_valid), .tx_load_ready(tx_load_ready),
		.tx_load_data(tx_load_data), .tx_done(tx_done), .rx_char_valid(rx_char_valid),
		.rx_char(rx_char), .rx_idle(rx_idle), .xfer_busy(xfer_busy), .ctrl(ctrl),
		.tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick),
		.serial_outputs_off(serial_outputs_off));

	sbr_far_model u_far (.pclk(pclk), .presetn(presetn), .tx_load_valid(tx_load_valid),
		.tx_load_data(tx_load_data), .tx_load_ready(tx_load_ready), .tx_done(tx_done),
		.xfer_busy(xfer_busy), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
		.rx_idle(rx_idle), .send_req(send_req), .send_data(send_data),
		.send_bit8(send_bit8), .got_data(got_data), .got_count(got_count));

	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until pready is sampled high; no latency assumed
	task apb(input logic wr, input logic [9:0] idx, input logic [7:0] d);
		int w;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= {idx, 2'h0};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		w = 0;
		do begin
			@(posedge pclk);
			w++;
		end while (pready !== 1'h1 && w < 50);
		if (w >= 50) chk(32'h0, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Skips the first tick, then counts cycles to the next one
	task period(input logic sel, output logic [31:0] cnt);
		int w;
		w = 0;
		do begin
			@(posedge pclk);
			w++;
		end while ((sel ? rx_bit_tick : tx_bit_tick) !== 1'h1 && w < 20000);
		cnt = 32'h0;
		do begin
			@(posedge pclk);
			cnt++;
		end while ((sel ? rx_bit_tick : tx_bit_tick) !== 1'h1 && cnt < 32'h4E20);
	endtask

	task rx_send(input logic [7:0] d, input logic b8);
		@(posedge pclk);
		send_data <= d;
		send_bit8 <= b8;
		send_req <= 1'h1;
		@(posedge pclk);
		send_req <= 1'h0;
		repeat (3) @(posedge pclk);
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge pclk);
		mismatches++;
		close_out;
	end

	initial begin
		presetn = 1'h0;
		{psel, penable, pwrite, send_req, send_bit8} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		send_data = 8'h00;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		foreach (reg_rows[i]) begin
			apb(reg_rows[i].wr, reg_rows[i].idx, reg_rows[i].d);
			chk({31'h0, err}, {31'h0, reg_rows[i].err});
			if (!reg_rows[i].wr) chk(rd, {24'h000000, reg_rows[i].exp});
		end
		foreach (rate_rows[i]) begin
			apb(1'h1, `SBR_IDX_TXEXT, rate_rows[i].txe);
			apb(1'h1, `SBR_IDX_RXEXT, rate_rows[i].rxe);
			apb(1'h1, `SBR_IDX_RATE, rate_rows[i].rate);
			period(1'h0, n);
			chk(n, rate_rows[i].txp);
			period(1'h1, n);
			chk(n, rate_rows[i].rxp);
		end
		// Second write lands while the far side is still busy with the first
		apb(1'h1, `SBR_IDX_DATA, 8'hA7);
		apb(1'h1, `SBR_IDX_DATA, 8'h3C);
		repeat (60) @(posedge pclk);
		chk({24'h0, got_count}, 32'h2);
		chk({24'h0, got_data}, 32'h3C);
		rx_send(8'h96, 1'h1);
		chk({31'h0, ctrl.ctrl_one[7]}, 32'h1);
		rx_send(8'h44, 1'h0);
		apb(1'h0, `SBR_IDX_STATUS, 8'h00);
		chk({30'h0, rd[5], rd[3]}, 32'h3);
		apb(1'h0, `SBR_IDX_DATA, 8'h00);
		chk(rd, 32'h96);
		apb(1'h0, `SBR_IDX_STATUS, 8'h00);
		chk({30'h0, rd[5], rd[3]}, 32'h0);
		apb(1'h1, `SBR_IDX_CTRL1, 8'h20);
		// Register write settles only after the access edge
		@(posedge pclk);
		chk({31'h0, ctrl.ctrl_one[5]}, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, serial_outputs_off}, 32'h1);
		n = 32'h0;
		repeat (400) begin
			@(posedge pclk);
			if (tx_bit_tick === 1'h1 || rx_bit_tick === 1'h1) n++;
		end
		chk(n, 32'h0);
		apb(1'h1, `SBR_IDX_CTRL1, 8'h00);
		@(posedge pclk);
		chk({31'h0, serial_outputs_off}, 32'h0);
		close_out;
	end
endmodule
